/* design/adc_ctl.sv */
// converter control register, conversion handshake and result formatting
`timescale 1ns/1ns
`include "adc_ctl_regs.svh"
module adc_ctl (
	input  wire logic        CORE_CLK,
	input  wire logic        SYS_RST,
	input  wire logic        WB_CYC_I,
	input  wire logic        WB_STB_I,
	input  wire logic        WB_WE_I,
	input  wire logic [7:0]  WB_ADR_I,
	input  wire logic [3:0]  WB_SEL_I,
	input  wire logic [31:0] WB_DAT_I,
	output logic      [31:0] WB_DAT_O,
	output logic             WB_ACK_O,
	output logic             IRQ,
	output logic             ANA_POWER,
	output logic      [7:0]  ANA_SEL_EXT,
	output logic             ANA_SEL_DAC,
	output logic             ANA_SEL_FVR,
	output logic             ANA_START,
	output logic             ANA_ABORT,
	input  wire logic        ANA_DONE,
	input  wire logic [9:0]  ANA_RESULT
);
	// ****************************************
	// bus decode
	// ****************************************
	logic                     ack_q;
	logic [31:0]              dat_q;
	adc_ctl_pkg::conv_state_t state_q;
	adc_ctl_pkg::conv_state_t state_d;
	logic                     fmt_q;
	logic [3:0]               chs_q;
	logic                     en_q;
	logic [7:0]               res_high_q;
	logic [7:0]               res_low_q;
	logic                     stat_q;
	logic                     mask_q;

	wire       req_w    = WB_CYC_I & WB_STB_I;
	wire       wr_w     = req_w & ack_q & WB_WE_I & WB_SEL_I[0]; // write lands at the acked edge
	wire       wr_ctl   = wr_w & (WB_ADR_I == `CTL_OFS);
	wire       wr_stat  = wr_w & (WB_ADR_I == `IRQ_STAT_OFS);
	wire       wr_mask  = wr_w & (WB_ADR_I == `IRQ_MASK_OFS);
	wire [7:0] wdat     = WB_DAT_I[7:0];
	wire       busy     = (state_q == adc_ctl_pkg::CONV_BUSY);
	wire [7:0] ctl_view = {fmt_q, 1'b0, chs_q, busy, en_q};
	// reset image of the control register, fields taken by position
	wire [7:0] ctl_rst_w = `CTL_RST;

	// ****************************************
	// conversion sequencing
	// ****************************************
	// completion wins over a clearing write in the same cycle
	wire done_w  = busy & ANA_DONE;
	wire start_w = wr_ctl & wdat[`GO_BIT] & wdat[`EN_BIT] & ~busy;
	wire abort_w = busy & ~done_w & wr_ctl & (~wdat[`GO_BIT] | ~wdat[`EN_BIT]);

	// state follows start, completion and abandon
	always_comb begin
		state_d = state_q;
		case (state_q)
			adc_ctl_pkg::CONV_IDLE: begin
				if (start_w) begin
					state_d = adc_ctl_pkg::CONV_BUSY;
				end
			end
			adc_ctl_pkg::CONV_BUSY: begin
				if (done_w | abort_w) begin
					state_d = adc_ctl_pkg::CONV_IDLE;
				end
			end
			default: state_d = adc_ctl_pkg::CONV_IDLE;
		endcase
	end

	// result placement by format at load time
	wire [7:0] load_high = fmt_q ? {6'h00, ANA_RESULT[9:8]} : ANA_RESULT[9:2];
	wire [7:0] load_low  = fmt_q ? ANA_RESULT[7:0] : {ANA_RESULT[1:0], 6'h00};

	// ****************************************
	// analog side
	// ****************************************
	assign ANA_POWER   = en_q;
	assign ANA_START   = start_w;
	assign ANA_ABORT   = abort_w;
	assign ANA_SEL_EXT = (en_q & ~chs_q[3]) ? (8'h01 << chs_q[2:0]) : 8'h00;
	assign ANA_SEL_DAC = en_q & (chs_q == `CHS_DAC);
	assign ANA_SEL_FVR = en_q & (chs_q == `CHS_FVR);
	assign IRQ         = stat_q & mask_q;

	// read mux, unmapped reads as zero
	wire [7:0] rd_byte = (WB_ADR_I == `CTL_OFS)      ? ctl_view   :
	                     (WB_ADR_I == `RES_HIGH_OFS) ? res_high_q :
	                     (WB_ADR_I == `RES_LOW_OFS)  ? res_low_q  :
	                     (WB_ADR_I == `IRQ_STAT_OFS) ? {7'h00, stat_q} :
	                     (WB_ADR_I == `IRQ_MASK_OFS) ? {7'h00, mask_q} : 8'h00;
	assign WB_ACK_O = ack_q;
	assign WB_DAT_O = dat_q;

	// ****************************************
	// registers
	// ****************************************
	// bus answer one cycle after the request
	always_ff @(posedge CORE_CLK) begin
		if (SYS_RST) begin
			ack_q <= 1'b0;
			dat_q <= 32'h0000_0000;
		end else begin
			ack_q <= req_w & ~ack_q;
			dat_q <= {24'h000000, rd_byte};
		end
	end

	// control fields and state
	always_ff @(posedge CORE_CLK) begin
		if (SYS_RST) begin
			state_q <= adc_ctl_pkg::CONV_IDLE;
			fmt_q   <= ctl_rst_w[`FMT_BIT];
			chs_q   <= ctl_rst_w[`CHS_HI:`CHS_LO];
			en_q    <= ctl_rst_w[`EN_BIT];
		end else begin
			state_q <= state_d;
			if (wr_ctl) begin
				fmt_q <= wdat[`FMT_BIT];
				chs_q <= wdat[`CHS_HI:`CHS_LO];
				en_q  <= wdat[`EN_BIT];
			end
		end
	end

	// result pair loads only on completion
	always_ff @(posedge CORE_CLK) begin
		if (SYS_RST) begin
			res_high_q <= `RES_RST;
			res_low_q  <= `RES_RST;
		end else if (done_w) begin
			res_high_q <= load_high;
			res_low_q  <= load_low;
		end
	end

	// sticky flag, set beats write-one-to-clear
	always_ff @(posedge CORE_CLK) begin
		if (SYS_RST) begin
			stat_q <= `IRQ_RST;
			mask_q <= `IRQ_RST;
		end else begin
			stat_q <= done_w | (stat_q & ~(wr_stat & wdat[`DONE_IRQ_BIT]));
			if (wr_mask) begin
				mask_q <= wdat[`DONE_IRQ_BIT];
			end
		end
	end

	// ****************************************
	// checks
	// ****************************************
	default clocking cb @(posedge CORE_CLK); endclocking
	default disable iff (SYS_RST);

	// completion clears the status bit and loads the pair
	a_done_clears_go:  assert property (done_w |=> !ctl_view[`GO_BIT] && !busy)
		else $error("status bit not cleared at completion");
	a_done_sets_flag:  assert property (done_w |=> stat_q)
		else $error("complete flag not set");
	a_right_high:      assert property (done_w && fmt_q |=> res_high_q == {6'h00, $past(ANA_RESULT[9:8])})
		else $error("right justified high byte wrong");
	a_right_low:       assert property (done_w && fmt_q |=> res_low_q == $past(ANA_RESULT[7:0]))
		else $error("right justified low byte wrong");
	a_left_pair:       assert property (done_w && !fmt_q |=> res_high_q == $past(ANA_RESULT[9:2])
		&& res_low_q == {$past(ANA_RESULT[1:0]), 6'h00})
		else $error("left justified pair wrong");
	// abandon keeps the old result and raises no flag
	a_abort_keeps_res: assert property (abort_w |=> $stable(res_high_q) && $stable(res_low_q) && !busy)
		else $error("abandon disturbed result");
	a_abort_no_flag:   assert property (abort_w && !stat_q |=> !stat_q)
		else $error("complete flag set by abandon");
	a_res_only_done:   assert property (!done_w |=> $stable(res_high_q) && $stable(res_low_q))
		else $error("result pair changed without completion");

	// converter power, start handling and channel routing
	a_power_gate:      assert property (busy |-> ANA_POWER)
		else $error("converting while off");
	a_off_no_route:    assert property (!en_q |-> ANA_SEL_EXT == 8'h00 && !ANA_SEL_DAC && !ANA_SEL_FVR)
		else $error("input routed while off");
	a_start_busy:      assert property (start_w |=> busy ##0 ctl_view[`GO_BIT])
		else $error("start did not hold status bit");
	a_go_kept_busy:    assert property (busy && !done_w && wr_ctl && wdat[`GO_BIT] && wdat[`EN_BIT] |=> busy)
		else $error("repeated start disturbed conversion");
	a_chan_dac:        assert property (en_q && chs_q == `CHS_DAC |-> ANA_SEL_DAC && ANA_SEL_EXT == 8'h00)
		else $error("dac channel decode wrong");
	a_chan_ext:        assert property (en_q && !chs_q[3] |-> $onehot(ANA_SEL_EXT) && ANA_SEL_EXT[chs_q[2:0]])
		else $error("external channel decode wrong");

	// register bus answer and interrupt mask
	a_ack_follows:     assert property (WB_CYC_I && WB_STB_I && !WB_ACK_O |=> WB_ACK_O)
		else $error("request not answered in one cycle");
	a_ack_single:      assert property (WB_ACK_O |=> !WB_ACK_O)
		else $error("acknowledge held too long");
	a_dat_upper_zero:  assert property (WB_DAT_O[31:8] == 24'h000000)
		else $error("read data upper bytes not zero");
	a_irq_masked:      assert property (!mask_q |-> !IRQ)
		else $error("interrupt raised while masked");

	// coverage of the main scenarios
	c_full_conv:  cover property (start_w ##[1:50] done_w);
	c_abort:      cover property (start_w ##[1:50] abort_w);
	c_irq_raise:  cover property (mask_q && done_w ##1 IRQ);
	c_chan_fvr:   cover property (ANA_SEL_FVR);
endmodule : adc_ctl

/* shared/adc_ctl_regs.svh */
// register offsets, field positions, reset values for the converter control block
`ifndef ADC_CTL_REGS_SVH
`define ADC_CTL_REGS_SVH
`define CTL_OFS        8'h00
`define RES_HIGH_OFS   8'h04
`define RES_LOW_OFS    8'h08
`define IRQ_STAT_OFS   8'h0c
`define IRQ_MASK_OFS   8'h10
`define FMT_BIT        7
`define CHS_HI         5
`define CHS_LO         2
`define GO_BIT         1
`define EN_BIT         0
`define DONE_IRQ_BIT   0
`define CTL_RST        8'h00
`define RES_RST        8'h00
`define IRQ_RST        1'h0
`define CHS_DAC        4'he
`define CHS_FVR        4'hf
`endif

/* shared/adc_ctl_pkg.sv */
// types shared by the converter control block
package adc_ctl_pkg;
	typedef enum logic {CONV_IDLE, CONV_BUSY} conv_state_t;
endpackage : adc_ctl_pkg

/* verification/ana_core_model.sv */
// behavioural model of the analog sample-and-convert core
`timescale 1ns/1ns
module ana_core_model (
	input  wire logic       CORE_CLK,
	input  wire logic       ANA_POWER,
	input  wire logic       ANA_START,
	input  wire logic       ANA_ABORT,
	input  wire logic [9:0] res_val,
	input  wire logic [7:0] dly,
	output logic            ANA_DONE,
	output logic      [9:0] ANA_RESULT
);
	int         cnt_q = 0;
	logic [9:0] last_q = 10'h000;
	// count the conversion time, then hand over one result for one cycle
	always @(posedge CORE_CLK) begin
		ANA_DONE <= 1'b0;
		ANA_RESULT <= ~last_q; // stale bus never repeats the last result
		if (ANA_ABORT) cnt_q <= 0; // abandoned
		else if (ANA_START) cnt_q <= int'(dly); // a start may power the core in the same write
		else if (!ANA_POWER) cnt_q <= 0; // unpowered core holds nothing
		else if (cnt_q == 1) begin
			ANA_DONE <= 1'b1; // completion pulse
			ANA_RESULT <= res_val;
			last_q <= res_val;
			cnt_q <= 0;
		end else if (cnt_q > 1) cnt_q <= cnt_q - 1;
	end
endmodule : ana_core_model

/* verification/tb_top.sv */
// self-checking bench for the converter control block
`timescale 1ns/1ns
module tb_top;
	logic        core_clk = 1'b0, sys_rst = 1'b1, cyc = 1'b0, stb = 1'b0, we = 1'b0;
	logic        ack, irq, pwr, sdac, sfvr, start, abort, done;
	logic [7:0]  adr = 8'h00, sext, rd_q;
	logic [31:0] dat = 32'h0, dato;
	logic [9:0]  res, rv = 10'h000;
	int          fail_count = 0, samples_checked = 0, cycles = 0, c;
	logic [7:0]  dly = 8'h0c;
	logic [3:0]  sel = 4'hf, sel_req = 4'hf;
	adc_ctl dut_u (.CORE_CLK(core_clk), .SYS_RST(sys_rst), .WB_CYC_I(cyc), .WB_STB_I(stb), .WB_WE_I(we),
		.WB_ADR_I(adr), .WB_SEL_I(sel), .WB_DAT_I(dat), .WB_DAT_O(dato), .WB_ACK_O(ack), .IRQ(irq),
		.ANA_POWER(pwr), .ANA_SEL_EXT(sext), .ANA_SEL_DAC(sdac), .ANA_SEL_FVR(sfvr), .ANA_START(start),
		.ANA_ABORT(abort), .ANA_DONE(done), .ANA_RESULT(res));
	ana_core_model core_u (.CORE_CLK(core_clk), .ANA_POWER(pwr), .ANA_START(start), .ANA_ABORT(abort),
		.res_val(rv), .dly(dly), .ANA_DONE(done), .ANA_RESULT(res));
	initial forever #5 core_clk = ~core_clk;
	// ********************************
	// bus access and comparison
	// ********************************
	task bus(input logic w, input logic [7:0] a, input logic [7:0] d);
		@(posedge core_clk);
		cyc <= 1'b1;
		stb <= 1'b1;
		we <= w;
		sel <= sel_req;
		adr <= a;
		dat <= {24'h0, d};
		do @(posedge core_clk); while (ack !== 1'b1);
		rd_q = dato[7:0];
		cyc <= 1'b0;
		stb <= 1'b0;
		// one idle edge so a landed write is visible to the caller
		@(posedge core_clk);
	endtask : bus
	task chk(input logic [7:0] g, input logic [7:0] e);
		samples_checked++;
		if (g !== e) begin
			fail_count++;
			$display("unexpected at %0t: got %h expected %h", $time, g, e);
		end
	endtask : chk
	task conv(input logic [7:0] cv, input logic [9:0] r, input logic [7:0] eh, input logic [7:0] el);
		int i;
		rv <= r;
		bus(1'b1, 8'h00, cv);
		bus(1'b0, 8'h00, 8'h00);
		chk({7'h0, rd_q[1]}, 8'h01);
		for (i = 0; i < 40 && rd_q[1]; i++) bus(1'b0, 8'h00, 8'h00);
		chk(rd_q, cv & 8'hfd);
		bus(1'b0, 8'h04, 8'h00);
		chk(rd_q, eh);
		bus(1'b0, 8'h08, 8'h00);
		chk(rd_q, el);
	endtask : conv
	task end_of_test;
		if (fail_count == 0 && samples_checked > 0) $display("Test passed");
		else $display("Test failed");
		$finish;
	endtask : end_of_test
	// cut a hang short
	always @(posedge core_clk) begin
		cycles++;
		if (cycles > 5000) begin
			fail_count++;
			end_of_test;
		end
	end
	// main sequence
	initial begin
		repeat (5) @(posedge core_clk);
		sys_rst <= 1'b0;
		bus(1'b0, 8'h00, 8'h00);
		chk(rd_q, 8'h00);
		bus(1'b1, 8'h10, 8'h01);
		conv(8'h83, 10'h2a5, 8'h02, 8'ha5);
		chk({7'h0, irq}, 8'h01);
		bus(1'b1, 8'h0c, 8'h01);
		chk({7'h0, irq}, 8'h00);
		conv(8'h03, 10'h2a5, 8'ha9, 8'h40);
		chk({7'h0, irq}, 8'h01);
		bus(1'b1, 8'h10, 8'h00);
		chk({7'h0, irq}, 8'h00);
		// a write without byte lane zero is ignored
		sel_req = 4'he;
		bus(1'b1, 8'h10, 8'h01);
		sel_req = 4'hf;
		bus(1'b0, 8'h10, 8'h00);
		chk(rd_q, 8'h00);
		bus(1'b0, 8'h0c, 8'h00);
		chk(rd_q, 8'h01);
		dly <= 8'h3c;
		rv <= 10'h3ff;
		bus(1'b1, 8'h00, 8'h83);
		bus(1'b1, 8'h00, 8'h01);
		repeat (70) @(posedge core_clk);
		bus(1'b0, 8'h04, 8'h00);
		chk(rd_q, 8'ha9);
		bus(1'b0, 8'h08, 8'h00);
		chk(rd_q, 8'h40);
		bus(1'b0, 8'h00, 8'h00);
		chk(rd_q, 8'h01);
		for (c = 0; c < 16; c++) if (c < 8 || c > 13) begin
			bus(1'b1, 8'h00, {2'b00, c[3:0], 2'b01});
			chk(sext, c < 8 ? 8'h01 << c : 8'h00);
			chk({7'h0, sdac}, {7'h0, c == 14});
			chk({7'h0, sfvr}, {7'h0, c == 15});
			chk({7'h0, pwr}, 8'h01);
		end
		bus(1'b1, 8'h00, 8'h00);
		chk({7'h0, pwr}, 8'h00);
		chk({7'h0, sfvr}, 8'h00);
		bus(1'b0, 8'h20, 8'h00);
		chk(rd_q, 8'h00);
		end_of_test;
	end
endmodule : tb_top
